//--- design/bcc_exec.sv
// Execution unit for bit test skip, clears, complement, compare, watchdog clear
//
// How it works
// - Bit test on any register, skip when set
// - Skip discards the instruction presented in the next cycle, two cycles
// - Clear accumulator loads zero, sets zero flag
// - Clear register writes zero, sets zero flag
// - Complement register into accumulator or register
// - Watchdog clear resets counter, prescaler if assigned
// - Watchdog clear sets timeout and powerdown flags
// - Compare register minus accumulator, nothing stored
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"

module bcc_exec
    import bcc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Instruction slot
    input  wire logic                   op_valid,
    input  wire bcc_op_e                op_code,
    input  wire logic [`BCC_ADDR_W-1:0] op_addr,
    input  wire logic [`BCC_BIT_W-1:0]  op_bit,
    input  wire logic                   op_dest,
    output logic                        op_ready,
    output logic                        op_discard,
    // Preload of core state
    input  wire logic                   acc_load,
    input  wire logic [`BCC_DATA_W-1:0] acc_load_data,
    input  wire logic                   ram_load,
    input  wire logic [`BCC_ADDR_W-1:0] ram_load_addr,
    input  wire logic [`BCC_DATA_W-1:0] ram_load_data,
    // Watchdog side
    input  wire logic                   prescaler_to_wdt,
    output logic                        wdt_clear,
    output logic                        prescaler_clear,
    // Core state
    output logic [`BCC_DATA_W-1:0]      accumulator,
    output logic                        zero_flag,
    output logic                        carry_flag,
    output logic                        timeout_flag_n,
    output logic                        powerdown_flag_n
);

    bcc_rf_if rf ();

    bcc_file_regs u_regs (
        .clk (clk),
        .rst (rst),
        .rf  (rf.mem)
    );

    bcc_state_e             state_r;
    bcc_state_e             state_nxt;
    logic                   exec_go;
    logic                   bit_set;
    logic [`BCC_DATA_W:0]   diff;
    logic [`BCC_DATA_W-1:0] comp;

    // =========================================================
    // Decode
    // Register preload owns the storage port, so an operation waits for it
    assign op_ready   = (state_r == BCC_ST_EXEC) && !ram_load;
    assign exec_go    = op_valid && op_ready;
    assign op_discard = op_valid && (state_r == BCC_ST_SKIP);
    assign bit_set    = rf.rd_data[op_bit];
    assign comp       = ~rf.rd_data;
    // Extra top bit is the borrow out of the subtraction
    assign diff = {1'h0, rf.rd_data} - {1'h0, accumulator};

    assign rf.addr = ram_load ? ram_load_addr : op_addr;

    always_comb begin
        rf.wr_en   = 1'b0;
        rf.wr_data = ram_load_data;
        if (ram_load) begin
            rf.wr_en = 1'b1;
        end else if (exec_go && op_code == BCC_OP_CLRREG) begin
            rf.wr_en   = 1'b1;
            rf.wr_data = `BCC_ZERO_BYTE;
        end else if (exec_go && op_code == BCC_OP_COMREG && op_dest == `BCC_DEST_REG) begin
            rf.wr_en   = 1'b1;
            rf.wr_data = comp;
        end
    end

    // =========================================================
    // Sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BCC_ST_EXEC: begin
                if (exec_go && op_code == BCC_OP_TBSS && bit_set) begin
                    state_nxt = BCC_ST_SKIP;
                end
            end
            // The NOP slot lasts one cycle whether or not a word arrives
            BCC_ST_SKIP: state_nxt = BCC_ST_EXEC;
            default:     state_nxt = BCC_ST_EXEC;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= BCC_ST_EXEC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // =========================================================
    // Accumulator
    always_ff @(posedge clk) begin
        if (rst) begin
            accumulator <= `BCC_ACC_RST;
        end else if (exec_go && op_code == BCC_OP_CLRACC) begin
            accumulator <= `BCC_ZERO_BYTE;
        end else if (exec_go && op_code == BCC_OP_COMREG && op_dest == `BCC_DEST_ACC) begin
            accumulator <= comp;
        end else if (acc_load && !exec_go) begin
            accumulator <= acc_load_data;
        end
    end

    // =========================================================
    // Zero and carry
    always_ff @(posedge clk) begin
        if (rst) begin
            zero_flag  <= `BCC_FLAG_RST;
            carry_flag <= `BCC_FLAG_RST;
        end else if (exec_go) begin
            case (op_code)
                BCC_OP_CLRACC: zero_flag <= 1'b1;
                BCC_OP_CLRREG: zero_flag <= 1'b1;
                BCC_OP_COMREG: zero_flag <= (comp == `BCC_ZERO_BYTE);
                BCC_OP_COMPARE: begin
                    zero_flag  <= (diff[`BCC_DATA_W-1:0] == `BCC_ZERO_BYTE);
                    carry_flag <= !diff[`BCC_DATA_W];
                end
                default: zero_flag <= zero_flag;
            endcase
        end
    end

    // =========================================================
    // Watchdog clear
    assign wdt_clear       = exec_go && op_code == BCC_OP_WDTCLR;
    assign prescaler_clear = wdt_clear && prescaler_to_wdt;

    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_flag_n   <= `BCC_FLAG_N_RST;
            powerdown_flag_n <= `BCC_FLAG_N_RST;
        end else if (wdt_clear) begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
    end

    // =========================================================
    // Checks
    sequence s_tbss_hit;
        exec_go && op_code == BCC_OP_TBSS && bit_set;
    endsequence

    sequence s_nop_slot;
        state_r == BCC_ST_SKIP && !op_ready ##1 state_r == BCC_ST_EXEC;
    endsequence

    skip_slot_a: assert property (@(posedge clk) disable iff (rst)
        s_tbss_hit |=> s_nop_slot)
        else $error("bit test hit did not take exactly one extra slot");

    skip_miss_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_TBSS && !bit_set |=> state_r == BCC_ST_EXEC)
        else $error("bit test skipped on a clear bit");

    tbss_flags_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_TBSS |=> $stable(zero_flag) && $stable(carry_flag))
        else $error("bit test changed a flag");

    clr_acc_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_CLRACC |=> accumulator == `BCC_ZERO_BYTE && zero_flag)
        else $error("accumulator clear failed");

    clr_reg_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_CLRREG
        |-> rf.wr_en && rf.wr_data == `BCC_ZERO_BYTE
            ##1 zero_flag && (rf.rd_data == `BCC_ZERO_BYTE || rf.addr != $past(rf.addr)))
        else $error("register clear failed");

    comp_acc_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_COMREG && op_dest == `BCC_DEST_ACC
        |=> accumulator == ~$past(rf.rd_data) && zero_flag == ($past(rf.rd_data) == 8'hFF))
        else $error("complement into accumulator wrong");

    wdt_pulse_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_WDTCLR
        |-> wdt_clear && prescaler_clear == prescaler_to_wdt)
        else $error("watchdog clear pulses wrong");

    wdt_flags_a: assert property (@(posedge clk) disable iff (rst)
        wdt_clear |=> timeout_flag_n && powerdown_flag_n && $stable(zero_flag))
        else $error("watchdog clear status wrong");

    cmp_flags_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_COMPARE
        |=> carry_flag == ($past(rf.rd_data) >= $past(accumulator))
            && zero_flag == ($past(rf.rd_data) == $past(accumulator))
            && $stable(accumulator))
        else $error("compare flags wrong or accumulator changed");

    cmp_nowrite_a: assert property (@(posedge clk) disable iff (rst)
        exec_go && op_code == BCC_OP_COMPARE |-> !rf.wr_en)
        else $error("compare wrote a register");

endmodule

`default_nettype wire

//--- design/bcc_defs.svh
// Constants for the bit, clear and compare execution block
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH

`define BCC_DATA_W      8
`define BCC_ADDR_W      7
`define BCC_BIT_W       3
`define BCC_REG_COUNT   128
`define BCC_ADDR_MAX    7'h7F
`define BCC_ZERO_BYTE   8'h00
`define BCC_ACC_RST     8'h00
`define BCC_FLAG_RST    1'h0
`define BCC_FLAG_N_RST  1'h1
`define BCC_DEST_ACC    1'h0
`define BCC_DEST_REG    1'h1
`define BCC_SKIP_CYCLES 2

`endif

//--- design/bcc_pkg.sv
// Types for the bit, clear and compare execution block
package bcc_pkg;

    // Instruction selector presented with each operation
    typedef enum logic [2:0] {
        BCC_OP_NOP     = 3'h0,
        BCC_OP_TBSS    = 3'h1,
        BCC_OP_CLRACC  = 3'h2,
        BCC_OP_CLRREG  = 3'h3,
        BCC_OP_COMREG  = 3'h4,
        BCC_OP_WDTCLR  = 3'h5,
        BCC_OP_COMPARE = 3'h6
    } bcc_op_e;

    // Execution state, one-hot
    typedef enum logic [1:0] {
        BCC_ST_EXEC = 2'b01,
        BCC_ST_SKIP = 2'b10
    } bcc_state_e;

endpackage

//--- design/bcc_rf_if.sv
// Port between the execution unit and the file register storage
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"

interface bcc_rf_if;
    logic [`BCC_ADDR_W-1:0] addr;
    logic                   wr_en;
    logic [`BCC_DATA_W-1:0] wr_data;
    logic [`BCC_DATA_W-1:0] rd_data;

    modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
    modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

`default_nettype wire

//--- design/bcc_file_regs.sv
// File register storage, one byte per address
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"

module bcc_file_regs
    import bcc_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Storage port
    bcc_rf_if.mem     rf
);

    logic [`BCC_DATA_W-1:0] mem_r [`BCC_REG_COUNT];

    // =========================================================
    // Storage entries
    genvar gi;
    generate
        for (gi = 0; gi < `BCC_REG_COUNT; gi++) begin : g_ent
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_r[gi] <= `BCC_ZERO_BYTE;
                end else if (rf.wr_en && rf.addr == `BCC_ADDR_W'(gi)) begin
                    mem_r[gi] <= rf.wr_data;
                end
            end
        end
    endgenerate

    // Read is combinational so an operation finishes in its own cycle
    assign rf.rd_data = mem_r[rf.addr];

endmodule

`default_nettype wire

//--- dv/bcc_exec_tb.sv
// Self-checking testbench for the bit, clear and compare execution block
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module bcc_exec_tb
    import bcc_pkg::*;
;
    // ==========================================
    // Stimulus and design
    logic clk = 0, rst = 1, op_valid = 0, op_dest = 0, acc_load = 0, ram_load = 0;
    logic prescaler_to_wdt = 0;
    bcc_op_e op_code = BCC_OP_NOP;
    logic [6:0] op_addr = 0, ram_load_addr = 0;
    logic [2:0] op_bit = 0;
    logic [7:0] acc_load_data = 0, ram_load_data = 0, accumulator;
    logic op_ready, op_discard, wdt_clear, prescaler_clear;
    logic zero_flag, carry_flag, timeout_flag_n, powerdown_flag_n;
    int miscompares = 0, samples_checked = 0;
    integer seed = 32'h35c2;

    always #12.5 clk = ~clk;

    bcc_exec dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .op_addr(op_addr), .op_bit(op_bit), .op_dest(op_dest), .op_ready(op_ready),
        .op_discard(op_discard), .acc_load(acc_load), .acc_load_data(acc_load_data),
        .ram_load(ram_load), .ram_load_addr(ram_load_addr), .ram_load_data(ram_load_data),
        .prescaler_to_wdt(prescaler_to_wdt), .wdt_clear(wdt_clear),
        .prescaler_clear(prescaler_clear), .accumulator(accumulator), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n));

    // ==========================================
    // Reference model, updated at each edge from what was taken
    logic [7:0] mem [128];
    logic [7:0] m_acc = 0, g_ad = 0, g_rd = 0, p_ad, p_rd;
    logic m_z = 0, m_c = 0, m_to = 1, m_pd = 1, skip = 0;
    logic p_v = 0, p_d, p_la = 0, p_lr = 0;
    bcc_op_e p_op;
    logic [6:0] p_a = 0, g_ra = 0, p_ra;
    logic [2:0] p_b;

    task automatic give_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Compare flags: zero on equal, carry when no borrow
    function automatic logic [1:0] cmp_exp(input logic [7:0] rv, input logic [7:0] av);
        return {rv == av, rv >= av};
    endfunction

    task automatic step(input logic v, input bcc_op_e op, input logic [6:0] a,
                        input logic [2:0] b, input logic d, input logic la, input logic lr);
        logic [7:0] r;
        logic       rdy;
        @(posedge clk);
        r = mem[p_a];
        skip = 0;
        if (p_v) begin
            case (p_op)
                BCC_OP_TBSS:   skip = r[p_b];
                BCC_OP_CLRACC: begin m_acc = 8'h00; m_z = 1; end
                BCC_OP_CLRREG: begin mem[p_a] = 8'h00; m_z = 1; end
                BCC_OP_COMREG: begin
                    if (p_d) mem[p_a] = ~r;
                    else m_acc = ~r;
                    m_z = (r == 8'hFF);
                end
                BCC_OP_WDTCLR: begin m_to = 1; m_pd = 1; end
                BCC_OP_COMPARE: {m_z, m_c} = cmp_exp(r, m_acc);
                default: ;
            endcase
        end
        if (p_la) m_acc = p_ad;
        if (p_lr) mem[p_ra] = p_rd;
        op_valid <= v; op_code <= op; op_addr <= a; op_bit <= b; op_dest <= d;
        acc_load <= la; acc_load_data <= g_ad;
        ram_load <= lr; ram_load_addr <= g_ra; ram_load_data <= g_rd;
        prescaler_to_wdt <= 1'($random(seed));
        #1;
        rdy = !skip && !lr;
        `CHK(accumulator, m_acc)
        `CHK(zero_flag, m_z)
        `CHK(carry_flag, m_c)
        `CHK({timeout_flag_n, powerdown_flag_n}, {m_to, m_pd})
        `CHK(op_ready, rdy)
        `CHK(op_discard, skip && v)
        `CHK(wdt_clear, v && rdy && op == BCC_OP_WDTCLR)
        `CHK(prescaler_clear, v && rdy && op == BCC_OP_WDTCLR && prescaler_to_wdt)
        p_v = v && rdy; p_op = op; p_a = a; p_b = b; p_d = d;
        p_la = la; p_ad = g_ad; p_lr = lr; p_ra = g_ra; p_rd = g_rd;
    endtask

    // Preload one register and the accumulator in a single idle cycle
    task automatic pre(input logic [6:0] ra, input logic [7:0] rd, input logic [7:0] ad);
        g_ra = ra; g_rd = rd; g_ad = ad;
        step(0, BCC_OP_NOP, 0, 0, 0, 1, 1);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic        v;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 0;
        // Compare: greater, equal, borrow
        pre(7'h7F, 8'h34, 8'h12);
        step(1, BCC_OP_COMPARE, 7'h7F, 0, 0, 0, 0);
        pre(7'h00, 8'h34, 8'h34);
        step(1, BCC_OP_COMPARE, 7'h00, 0, 0, 0, 0);
        pre(7'h00, 8'h33, 8'h34);
        step(1, BCC_OP_COMPARE, 7'h00, 0, 0, 0, 0);
        // Skip on set bit, next word discarded, then a miss
        pre(7'h7F, 8'h80, 8'h55);
        step(1, BCC_OP_TBSS, 7'h7F, 3'h7, 0, 0, 0);
        step(1, BCC_OP_CLRACC, 0, 0, 0, 0, 0);
        step(1, BCC_OP_TBSS, 7'h7F, 3'h6, 0, 0, 0);
        // Complement both ways, clear register, watchdog clear
        pre(7'h05, 8'hA6, 8'h00);
        step(1, BCC_OP_COMREG, 7'h05, 0, 1, 0, 0);
        step(1, BCC_OP_COMREG, 7'h05, 0, 0, 0, 0);
        step(1, BCC_OP_CLRREG, 7'h05, 0, 0, 0, 0);
        step(1, BCC_OP_WDTCLR, 0, 0, 0, 0, 0);
        step(1, BCC_OP_COMPARE, 7'h05, 0, 0, 0, 0);
        // Op held while a preload blocks it
        step(1, BCC_OP_CLRACC, 0, 0, 0, 0, 1);
        step(1, BCC_OP_CLRACC, 0, 0, 0, 0, 0);
        // Random mix on few addresses so hits are frequent
        for (int i = 0; i < 2000; i++) begin
            r = $random(seed);
            v = r[3];
            g_ad = r[31:24];
            g_rd = r[23:16];
            g_ra = r[14] ? 7'h7F : {4'h0, r[22:20]};
            step(v, bcc_op_e'(r[2:0] == 3'h7 ? 3'h6 : r[2:0]),
                 r[6] ? 7'h7F : {4'h0, r[10:8]}, r[13:11], r[7],
                 !v && r[4], !v && r[5]);
        end
        step(0, BCC_OP_NOP, 0, 0, 0, 0, 0);
        give_verdict();
    end

    // Hang guard
    initial begin
        #(25 * 20000);
        miscompares++;
        give_verdict();
    end
endmodule

`default_nettype wire
